// >>> core/trs_top.sv
// temperature result formatting, background conversion and shutdown
// assumes sensor_code and the thermostat inputs come from logic on
// clk_sys; scl_link is the host's serial clock, stopped between frames
//
// Contract
// - converts from reset, 9-bit by default
// - resolution 9..12 bits from two-bit field
// - conversion 150 ms, doubling per extra bit
// - each result stored as 16-bit two's complement
// - bit 15 sign, bits 14..4 weighted
// - bits 3..0 always read zero
// - only resolution-wide top bits carry data
// - reads never disturb a running conversion
// - halt bit: finish, store, then standby
// - entering standby clears alarm in interrupt mode unless thermo_irq_event is high that cycle
// - link works in standby; writing 0 resumes
// - interrupt alarm cleared by standby or read
`timescale 1ns/1ps
`default_nettype none
module trs_top #(
  parameter int unsigned CONV_9BIT_CYCLES = trs_pkg::CONV_9BIT_CYCLES
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial link
  input wire logic scl_link,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // converter and thermostat
  input wire logic [trs_pkg::CODE_W-1:0] sensor_code,
  input wire logic thermo_cmp_level,
  input wire logic thermo_irq_event,
  // status
  output logic alarm_active,
  output logic standby_active
);

  localparam int TW = trs_pkg::TIMER_W;

  // ****************************************
  // system domain state
  // ****************************************
  trs_pkg::trs_state_t state_reg;
  logic [TW-1:0] timer_reg, limit_cycles;
  logic [1:0] res_conv_reg, pins_s, tgl_s;
  logic [trs_pkg::TEMP_W-1:0] temperature_reading_reg, temp_hold_reg;
  logic [trs_pkg::TEMP_W-1:0] res_mask, temp_next;
  logic [trs_pkg::CFG_W-1:0] cfg_reg, cfg_hold_reg;
  logic frame_reg, link_rst_reg, scl_prev_reg, sda_prev_reg;
  logic wr_seen_reg, rd_seen_reg, wr_pulse, rd_pulse;
  logic frame_start, frame_stop, frame_next;
  logic conv_done, halt_req, irq_mode;

  // ****************************************
  // link domain state
  // ****************************************
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic [6:0] shift_in_reg;
  logic [trs_pkg::SHIFT_W-1:0] out_shift_reg;
  logic [trs_pkg::CFG_W-1:0] cfg_link_reg, byte_in;
  logic cmd_read_reg, wr_tgl_reg, rd_tgl_reg, link_rst;

  // ****************************************
  // crossings
  // ****************************************
  // pins sampled on clk_sys only to find frame edges
  trs_sync2 #(.WIDTH(2)) u_pin_sync (
    .clk(clk_sys),
    .rst(rst),
    .async_in({scl_link, sda_in}),
    .sync_out(pins_s)
  );

  // event toggles from the link domain
  trs_sync2 #(.WIDTH(2)) u_tgl_sync (
    .clk(clk_sys),
    .rst(rst),
    .async_in({wr_tgl_reg, rd_tgl_reg}),
    .sync_out(tgl_s)
  );

  // ****************************************
  // frame tracking on clk_sys
  // ****************************************
  // start: data falls while clock high; stop: data rises while clock high
  assign frame_start = pins_s[1] & scl_prev_reg & sda_prev_reg & ~pins_s[0];
  assign frame_stop = pins_s[1] & scl_prev_reg & ~sda_prev_reg & pins_s[0];
  assign frame_next = frame_start | (frame_reg & ~frame_stop);
  assign wr_pulse = tgl_s[1] ^ wr_seen_reg;
  assign rd_pulse = tgl_s[0] ^ rd_seen_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      frame_reg <= 1'b0;
      link_rst_reg <= 1'b1;
      wr_seen_reg <= 1'b0;
      rd_seen_reg <= 1'b0;
    end else begin
      scl_prev_reg <= pins_s[1];
      sda_prev_reg <= pins_s[0];
      frame_reg <= frame_next;
      link_rst_reg <= ~frame_next; // holds the link engine idle between frames
      wr_seen_reg <= tgl_s[1];
      rd_seen_reg <= tgl_s[0];
    end
  end

  // snapshots only move outside frames, so the link sees stable words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      temp_hold_reg <= '0;
      cfg_hold_reg <= trs_pkg::CFG_RESET;
    end else if (!frame_reg) begin
      temp_hold_reg <= temperature_reading_reg;
      cfg_hold_reg <= cfg_reg;
    end
  end

  // settings byte; reserved bit never stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= trs_pkg::CFG_RESET;
    end else if (wr_pulse) begin
      cfg_reg <= cfg_link_reg & ~(8'h01 << trs_pkg::CFG_RSVD_BIT);
    end
  end

  // ****************************************
  // conversion sequencing
  // ****************************************
  assign halt_req = cfg_reg[trs_pkg::CFG_HALT_BIT];
  assign irq_mode = cfg_reg[trs_pkg::CFG_TM_BIT];
  assign limit_cycles = TW'(CONV_9BIT_CYCLES) << res_conv_reg;
  assign conv_done = (state_reg == trs_pkg::st_converting) &&
                     (timer_reg == limit_cycles - TW'(1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= trs_pkg::st_converting;
      timer_reg <= '0;
      res_conv_reg <= trs_pkg::RES_9BIT;
    end else begin
      unique case (state_reg)
        trs_pkg::st_converting: begin
          // a finished conversion always lands before standby
          if (conv_done) begin
            timer_reg <= '0;
            res_conv_reg <= cfg_reg[trs_pkg::CFG_RES_LSB +: 2];
            if (halt_req) begin
              state_reg <= trs_pkg::st_standby;
            end
          end else begin
            timer_reg <= timer_reg + TW'(1);
          end
        end
        trs_pkg::st_standby: begin
          if (!halt_req) begin
            state_reg <= trs_pkg::st_converting;
            timer_reg <= '0;
            res_conv_reg <= cfg_reg[trs_pkg::CFG_RES_LSB +: 2];
          end
        end
      endcase
    end
  end

  // ****************************************
  // result formatting
  // ****************************************
  // truncation, not rounding: finer bits simply drop away
  assign res_mask = ~(trs_pkg::RES9_DROP_MASK >> res_conv_reg);
  assign temp_next = {sensor_code, trs_pkg::LOW_NIBBLE_ZERO} & res_mask;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      temperature_reading_reg <= '0;
    end else if (conv_done) begin
      temperature_reading_reg <= temp_next;
    end
  end

  // ****************************************
  // alarm output
  // ****************************************
  // interrupt mode: set wins over a clear landing in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_active <= 1'b0;
    end else if (!irq_mode) begin
      if (conv_done) begin
        alarm_active <= thermo_cmp_level;
      end
    end else if (thermo_irq_event && state_reg == trs_pkg::st_converting) begin
      alarm_active <= 1'b1;
    end else if (rd_pulse || (conv_done && halt_req)) begin
      alarm_active <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      standby_active <= 1'b0;
    end else begin
      standby_active <= (state_reg == trs_pkg::st_standby);
    end
  end

  // ****************************************
  // link engine on scl_link
  // ****************************************
  assign link_rst = rst | link_rst_reg;
  assign byte_in = {shift_in_reg, sda_in};

  // bit and byte counting on rising clock; data is valid then
  always_ff @(posedge scl_link or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_reg <= trs_pkg::BIT_FIRST;
      byte_idx_reg <= trs_pkg::BYTE_CMD;
      shift_in_reg <= '0;
      cmd_read_reg <= 1'b0;
    end else begin
      if (bit_cnt_reg == trs_pkg::BIT_ACK) begin
        bit_cnt_reg <= trs_pkg::BIT_FIRST;
        if (byte_idx_reg != trs_pkg::BYTE_LAST) begin
          byte_idx_reg <= byte_idx_reg + 2'd1;
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'd1;
        shift_in_reg <= byte_in[6:0];
      end
      if (bit_cnt_reg == trs_pkg::BIT_LAST &&
          byte_idx_reg == trs_pkg::BYTE_CMD) begin
        cmd_read_reg <= byte_in[trs_pkg::CMD_READ_BIT];
      end
    end
  end

  // word and toggles survive the idle reset so no false event appears
  always_ff @(posedge scl_link or posedge rst) begin
    if (rst) begin
      cfg_link_reg <= trs_pkg::CFG_RESET;
      wr_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
    end else if (!link_rst_reg && bit_cnt_reg == trs_pkg::BIT_LAST) begin
      if (byte_idx_reg == trs_pkg::BYTE_CMD &&
          byte_in[trs_pkg::CMD_READ_BIT]) begin
        rd_tgl_reg <= ~rd_tgl_reg;
      end else if (byte_idx_reg == trs_pkg::BYTE_CFG && !cmd_read_reg) begin
        cfg_link_reg <= byte_in;
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // data changes on the falling clock, held through the high phase
  always_ff @(negedge scl_link or posedge link_rst) begin
    if (link_rst) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0; // open drain: only ever pulls low
      out_shift_reg <= '0;
    end else if (bit_cnt_reg == trs_pkg::BIT_ACK) begin
      sda_oe <= (byte_idx_reg == trs_pkg::BYTE_CMD) ||
                (byte_idx_reg == trs_pkg::BYTE_CFG && !cmd_read_reg);
      if (byte_idx_reg == trs_pkg::BYTE_CMD) begin
        out_shift_reg <= {temp_hold_reg, cfg_hold_reg};
      end
    end else if (cmd_read_reg && byte_idx_reg != trs_pkg::BYTE_CMD) begin
      sda_oe <= ~out_shift_reg[trs_pkg::SHIFT_W-1];
      // ones fill in, so spare clocks release the wire for the stop
      out_shift_reg <= {out_shift_reg[trs_pkg::SHIFT_W-2:0], 1'b1};
    end else begin
      sda_oe <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_boot_nine_bit: assert property (
    $past(rst) |-> state_reg == trs_pkg::st_converting &&
                   res_conv_reg == trs_pkg::RES_9BIT)
    else $error("conversion not running at 9 bits after reset");
  chk_step_mask: assert property (
    conv_done |=> (temperature_reading_reg &
                   (trs_pkg::RES9_DROP_MASK >> $past(res_conv_reg))) == '0)
    else $error("result holds bits finer than its resolution");
  chk_conv_length: assert property (
    conv_done |-> 32'(timer_reg) + 1 ==
                  CONV_9BIT_CYCLES * (32'd1 << res_conv_reg))
    else $error("conversion length wrong for resolution");
  chk_result_store: assert property (
    conv_done |=> temperature_reading_reg[15:7] == $past(sensor_code[11:3]))
    else $error("completed result not stored");
  chk_sign_bit: assert property (
    conv_done |=> temperature_reading_reg[15] == $past(sensor_code[11]))
    else $error("sign bit wrong");
  chk_low_zero: assert property (
    temperature_reading_reg[3:0] == trs_pkg::LOW_NIBBLE_ZERO &&
    temp_hold_reg[3:0] == trs_pkg::LOW_NIBBLE_ZERO)
    else $error("low nibble not zero");
  chk_read_no_restart: assert property (
    rd_pulse && state_reg == trs_pkg::st_converting && !conv_done
    |=> timer_reg == $past(timer_reg) + TW'(1))
    else $error("read disturbed the conversion");
  chk_halt_after_done: assert property (
    $rose(standby_active) |-> $past(conv_done, 2))
    else $error("standby entered before conversion finished");
  chk_halt_alarm_clear: assert property (
    conv_done && halt_req && irq_mode && !thermo_irq_event |=> !alarm_active)
    else $error("alarm kept on standby entry in interrupt mode");
  chk_resume_on_clear: assert property (
    state_reg == trs_pkg::st_standby && !halt_req
    |=> state_reg == trs_pkg::st_converting && timer_reg == '0)
    else $error("no resume after halt bit cleared");
  chk_irq_clear_cause: assert property (
    irq_mode && $past(irq_mode) && $fell(alarm_active)
    |-> $past(rd_pulse) || ($past(conv_done) && $past(halt_req)))
    else $error("interrupt alarm cleared without cause");
  chk_back_to_back: assert property (
    conv_done && !halt_req |=> state_reg == trs_pkg::st_converting ##1
                               timer_reg == TW'(1))
    else $error("next conversion did not start at once");

  cov_conv_done: cover property (conv_done);
  cov_enter_standby: cover property ($rose(standby_active));
  cov_cfg_write: cover property (wr_pulse);
  cov_read_clear: cover property (rd_pulse && alarm_active && irq_mode);

endmodule
`default_nettype wire

// >>> core/trs_pkg.sv
// shared constants and types of the temperature result and shutdown block
// assumes a 50 MHz system clock and a serial link clocked by the host
package trs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  // longest 9-bit conversion time, in ms; each extra bit doubles it
  localparam int CONV_9BIT_MS = 150;
  // longest time rounds down: whole cycles that fit in it
  localparam int CONV_9BIT_CYCLES = CONV_9BIT_MS * (SYS_CLK_HZ / MS_PER_S);
  // wide enough for the 12-bit figure, eight times the 9-bit one
  localparam int TIMER_W = 27;

  // ****************************************
  // data widths and formats
  // ****************************************
  localparam int CODE_W = 12;
  localparam int TEMP_W = 16;
  localparam int CFG_W = 8;
  localparam int SHIFT_W = TEMP_W + CFG_W;
  localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;
  // bits below the 9-bit step; shifted right once per extra bit
  localparam logic [15:0] RES9_DROP_MASK = 16'h007F;

  // ****************************************
  // settings byte layout
  // ****************************************
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_HALT_BIT = 0;
  localparam int CFG_TM_BIT = 1;
  localparam int CFG_RES_LSB = 5;
  localparam int CFG_RSVD_BIT = 7;
  localparam logic [1:0] RES_9BIT = 2'h0;

  // ****************************************
  // link framing
  // ****************************************
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [1:0] BYTE_CMD = 2'h0;
  localparam logic [1:0] BYTE_CFG = 2'h1;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam int CMD_READ_BIT = 0;

  typedef enum logic {st_converting, st_standby} trs_state_t;

endpackage

// >>> core/trs_sync2.sv
// two flip-flop synchroniser for a group of independent levels
// assumes each bit changes slowly against clk
`timescale 1ns/1ps
`default_nettype none
module trs_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// >>> dv/trs_host_model.sv
// host side of the serial link: clock maker and open-drain data driver
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module trs_host_model (
  // link lines
  output logic scl,
  output logic sda_low,
  input wire logic sda_wire
);
  // ****************************************
  // timing of the 32 ns link clock
  // ****************************************
  // low phase outlasts one system period, so the device's sampled pins
  // never see the clock high on both sides of a data change
  localparam int SETUP_NS = 4;
  localparam int LOW_NS = 18;
  localparam int HIGH_NS = 10;
  // gap after start and after stop, beyond the 200 ns the device needs
  localparam int GAP_NS = 240;

  // clock stands high between frames, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ****************************************
  // frame pieces
  // ****************************************
  // data moves just after the fall, sampled at the rise
  task automatic slot(input logic drive_low, output logic seen);
    #SETUP_NS sda_low = drive_low;
    #LOW_NS scl = 1'b1;
    seen = sda_wire;
    #HIGH_NS scl = 1'b0;
  endtask

  task automatic frame_open();
    sda_low = 1'b1;
    #GAP_NS scl = 1'b0;
  endtask

  task automatic frame_close();
    #SETUP_NS sda_low = 1'b1;
    #LOW_NS scl = 1'b1;
    // long high before the release, or the stop slips between samples
    #GAP_NS sda_low = 1'b0;
    #GAP_NS;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(~b[i], s);
    end
    slot(1'b0, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b0, s);
      b[i] = s;
    end
    slot(~last, s);
  endtask

  // ****************************************
  // whole frames
  // ****************************************
  // writing 0 to the halt bit is how the host resumes conversions
  task automatic write_cfg(input logic [7:0] v, output logic ok);
    logic a1;
    logic a2;
    frame_open();
    put_byte(8'h00, a1);
    put_byte(v, a2);
    frame_close();
    ok = a1 & a2;
  endtask

  task automatic read_all(output logic [15:0] t, output logic [7:0] c);
    logic a;
    frame_open();
    put_byte(8'h01, a);
    get_byte(1'b0, t[15:8]);
    get_byte(1'b0, t[7:0]);
    get_byte(1'b1, c);
    frame_close();
  endtask
endmodule
`default_nettype wire

// >>> dv/test_temp_result_register_shutdown.sv
// self-checking bench of the result register and shutdown block
// assumes trs_top, trs_pkg and the host model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_temp_result_register_shutdown;
  // ****************************************
  // clocks, wires and model state
  // ****************************************
  // short conversions keep the run small; 12-bit is 160 cycles
  localparam int CONV = 20;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic scl_link;
  logic host_low;
  logic sda_oe;
  logic sda_out;
  logic sda_wire;
  logic [trs_pkg::CODE_W-1:0] sensor_code = 12'h000;
  logic thermo_cmp_level = 1'b0;
  logic thermo_irq_event = 1'b0;
  logic alarm_active;
  logic standby_active;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int cfg_m = 0;

  always #10 clk_sys = ~clk_sys;
  // pull-up: low when either party pulls
  assign sda_wire = !(host_low || (sda_oe && !sda_out));

  trs_top #(.CONV_9BIT_CYCLES(CONV)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .scl_link(scl_link),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .sensor_code(sensor_code), .thermo_cmp_level(thermo_cmp_level),
    .thermo_irq_event(thermo_irq_event), .alarm_active(alarm_active),
    .standby_active(standby_active));

  trs_host_model host_u (.scl(scl_link), .sda_low(host_low),
    .sda_wire(sda_wire));

  // ****************************************
  // model and helpers
  // ****************************************
  // code sits at bits 15..4; only 9+res top bits survive
  function automatic logic [15:0] fmt(input int code, input int res);
    int v;
    v = (code & 'hFFF) << 4;
    return 16'(v & ('hFFFF << (7 - res)));
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] exp_t);
    logic [15:0] t;
    logic [7:0] c;
    host_u.read_all(t, c);
    cmp(t, exp_t);
    cmp({8'h00, c}, 16'(cfg_m & 'h7F));
  endtask

  // config lands a few cycles after the byte, so settle before going on
  task automatic wr(input logic [7:0] v);
    logic ok;
    host_u.write_cfg(v, ok);
    cmp({15'h0000, ok}, 16'h0001);
    cfg_m = v;
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic setc(input logic [11:0] c);
    @(negedge clk_sys);
    sensor_code = c;
  endtask

  task automatic wait_stby(input logic lvl, input int lim);
    int k;
    k = 0;
    while (standby_active !== lvl && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    cmp({15'h0000, standby_active}, {15'h0000, lvl});
  endtask

  task automatic irq_pulse();
    @(negedge clk_sys);
    thermo_irq_event = 1'b1;
    @(negedge clk_sys);
    thermo_irq_event = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      end_sim();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [11:0] c0;
    logic [11:0] c1;
    logic [15:0] t_d;
    logic [7:0] c_d;
    int t0;
    int r;
    r = $urandom(32'h4529_795c);
    c0 = 12'($urandom);
    sensor_code = c0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (2 * CONV + 12) @(negedge clk_sys);
    rd_chk(fmt(c0, 0));
    wait_stby(1'b0, 1);
    $display("test power-up done");
    // each resolution, reserved bit thrown in at random
    for (r = 0; r < 4; r++) begin
      wr(8'(($urandom & 'h80) | (r << 5)));
      c0 = 12'($urandom);
      setc(c0);
      repeat (2 * (CONV << r) + 12) @(negedge clk_sys);
      rd_chk(fmt(c0, r));
    end
    $display("test resolutions done");
    // reads faster than one 12-bit conversion must not starve it
    c1 = 12'($urandom);
    setc(c1);
    t0 = cyc;
    while (cyc < t0 + 2 * (CONV << 3) + 20) host_u.read_all(t_d, c_d);
    rd_chk(fmt(c1, 3));
    $display("test busy reads done");
    // halt during a running conversion: its result is kept
    c1 = 12'($urandom);
    setc(c1);
    wr(8'h61);
    wait_stby(1'b1, 200);
    c0 = ~c1;
    setc(c0);
    repeat (400) @(negedge clk_sys);
    wait_stby(1'b1, 1);
    rd_chk(fmt(c1, 3));
    wr(8'h60);
    wait_stby(1'b0, 10);
    repeat (2 * (CONV << 3) + 12) @(negedge clk_sys);
    rd_chk(fmt(c0, 3));
    $display("test shutdown done");
    // interrupt mode: held until a read or a halt
    wr(8'h02);
    irq_pulse();
    cmp({15'h0000, alarm_active}, 16'h0001);
    repeat (200) @(negedge clk_sys);
    cmp({15'h0000, alarm_active}, 16'h0001);
    host_u.read_all(t_d, c_d);
    repeat (4) @(negedge clk_sys);
    cmp({15'h0000, alarm_active}, 16'h0000);
    irq_pulse();
    wr(8'h03);
    wait_stby(1'b1, 200);
    repeat (2) @(negedge clk_sys);
    cmp({15'h0000, alarm_active}, 16'h0000);
    // comparator mode: standby leaves the alarm alone
    wr(8'h00);
    thermo_cmp_level = 1'b1;
    repeat (2 * CONV + 12) @(negedge clk_sys);
    cmp({15'h0000, alarm_active}, 16'h0001);
    wr(8'h01);
    wait_stby(1'b1, 40);
    thermo_cmp_level = 1'b0;
    repeat (60) @(negedge clk_sys);
    cmp({15'h0000, alarm_active}, 16'h0001);
    $display("test alarm done");
    end_sim();
  end
endmodule
`default_nettype wire
